/* pkg/sub_skip_defs.svh */
// Purpose: register offsets, field positions and reset values of the execution block
// Assumes: byte addresses on an 8-bit AXI4-Lite address, one 32-bit word per register
// Notes:   definitions only
`ifndef SUB_SKIP_DEFS_SVH
`define SUB_SKIP_DEFS_SVH

`define OFF_CMD      8'h00
`define OFF_MEM      8'h04
`define OFF_ACC      8'h08
`define OFF_STATUS   8'h0C

`define BIT_C        0
`define BIT_AC       1
`define BIT_Z        2
`define BIT_OV       3
`define BIT_SKIP     4
`define BIT_BUSY     5

`define ACC_RESET    8'h00
`define MEM_RESET    8'h00
`define FLAGS_RESET  4'h0
`define SET_PATTERN  8'hFF
`define DEC_STEP     8'h01

`define RESP_OKAY    2'b00
`define RESP_SLVERR  2'b10

`endif

/* pkg/sub_skip_pkg.sv */
// Purpose: types shared by the execution block
// Assumes: nothing
// Notes:   opcode codes 6 and 7 are illegal
package sub_skip_pkg;

	typedef enum logic [1:0] {
		st_idle  = 2'b00,
		st_exec  = 2'b01,
		st_dummy = 2'b10
	} exec_state_t;

	typedef enum logic [2:0] {
		op_none               = 3'b000,
		op_sub_borrow_to_acc  = 3'b001,
		op_sub_borrow_to_mem  = 3'b010,
		op_dec_skip_zero_mem  = 3'b011,
		op_dec_skip_zero_acc  = 3'b100,
		op_set_byte           = 3'b101
	} op_t;

	typedef struct packed {
		logic [7:0] diff;
		logic       borrow;
		logic       half_borrow;
		logic       ovf;
	} sub_res_t;

endpackage

/* hw/subtract_skip_set_execution.sv */
// Purpose: subtract-with-borrow, decrement-and-skip and set-byte execution behind AXI4-Lite
// Assumes: one data memory byte held in the memory register, software issues one op at a time
// Notes:   register writes are ignored while an op is under way
// What this block does
// - acc minus mem minus not-carry into acc
// - carry cleared if negative, else set
// - same subtraction written back into memory
// - memory decremented, skip next when zero
// - acc gets mem minus one, mem kept
// - decrement ops take two cycles with dummy
// - nonzero decrement result means no skip
// - set byte writes all ones, flags kept
//
// The AXI4-Lite interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "sub_skip_defs.svh"
module subtract_skip_set_execution
	import sub_skip_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic             skip_next,
	output logic             dummy_cycle,
	output logic             busy
);

	function automatic logic reg_hit(input logic [7:0] addr);
		return (addr == `OFF_CMD) || (addr == `OFF_MEM) || (addr == `OFF_ACC) ||
			(addr == `OFF_STATUS);
	endfunction
	function automatic sub_res_t sub_borrow(input logic [7:0] a, input logic [7:0] m,
		input logic c);
		logic [8:0] full;
		logic [4:0] low;
		sub_res_t   r;
		full = {1'b0, a} - {1'b0, m} - {8'h00, ~c};
		low = {1'b0, a[3:0]} - {1'b0, m[3:0]} - {4'h0, ~c};
		r.diff = full[7:0];
		r.borrow = full[8];
		r.half_borrow = low[4];
		r.ovf = (a[7] ^ m[7]) & (a[7] ^ full[7]);
		return r;
	endfunction
	logic        awready_reg, awready_next, wready_reg, wready_next;
	logic        bvalid_reg, bvalid_next, arready_reg, arready_next;
	logic        rvalid_reg, rvalid_next, have_aw_reg, have_aw_next;
	logic        have_w_reg, have_w_next;
	logic [1:0]  bresp_reg, bresp_next, rresp_reg, rresp_next;
	logic [7:0]  waddr_reg, waddr_next;
	logic [31:0] wdata_reg, wdata_next, rdata_reg, rdata_next;
	logic [3:0]  wstrb_reg, wstrb_next;
	logic        wr_commit;
	exec_state_t state_reg, state_next;
	op_t         op_reg, op_next;
	logic [7:0]  accumulator_reg, accumulator_next, mem_reg, mem_next;
	logic        carry_flag, carry_next, aux_carry_flag, aux_carry_next;
	logic        zero_flag, zero_next, overflow_flag, overflow_next;
	logic        skip_reg, skip_nx, dummy_reg, dummy_next, busy_reg, busy_next;
	sub_res_t    sub_res;
	logic [7:0]  dec_res;
	logic [31:0] status_word;
	// both halves must be held; the response is raised one cycle after the second arrives
	assign wr_commit = have_aw_reg && have_w_reg && !bvalid_reg;
	assign sub_res = sub_borrow(accumulator_reg, mem_reg, carry_flag);
	assign dec_res = mem_reg - `DEC_STEP;
	assign status_word = {26'h000_0000, busy_reg, skip_reg, overflow_flag, zero_flag,
		aux_carry_flag, carry_flag};
	always_comb begin
		awready_next = awready_reg;
		wready_next = wready_reg;
		bvalid_next = bvalid_reg;
		bresp_next = bresp_reg;
		have_aw_next = have_aw_reg;
		have_w_next = have_w_reg;
		waddr_next = waddr_reg;
		wdata_next = wdata_reg;
		wstrb_next = wstrb_reg;
		arready_next = arready_reg;
		rvalid_next = rvalid_reg;
		rdata_next = rdata_reg;
		rresp_next = rresp_reg;
		if (s_axi_awvalid && awready_reg) begin
			have_aw_next = 1'b1;
			awready_next = 1'b0;
			waddr_next = s_axi_awaddr;
		end
		if (s_axi_wvalid && wready_reg) begin
			have_w_next = 1'b1;
			wready_next = 1'b0;
			wdata_next = s_axi_wdata;
			wstrb_next = s_axi_wstrb;
		end
		if (wr_commit) begin
			bvalid_next = 1'b1;
			bresp_next = reg_hit(waddr_reg) ? `RESP_OKAY : `RESP_SLVERR;
			have_aw_next = 1'b0;
			have_w_next = 1'b0;
		end
		// readies reopen only after the response, so one write is in flight at a time
		if (bvalid_reg && s_axi_bready) begin
			bvalid_next = 1'b0;
			awready_next = 1'b1;
			wready_next = 1'b1;
		end
		if (s_axi_arvalid && arready_reg) begin
			arready_next = 1'b0;
			rvalid_next = 1'b1;
			rresp_next = reg_hit(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
			unique case (s_axi_araddr)
				`OFF_CMD:    rdata_next = {29'h0000_0000, op_reg};
				`OFF_MEM:    rdata_next = {24'h00_0000, mem_reg};
				`OFF_ACC:    rdata_next = {24'h00_0000, accumulator_reg};
				`OFF_STATUS: rdata_next = status_word;
				default:     rdata_next = 32'h0000_0000;
			endcase
		end else if (rvalid_reg && s_axi_rready) begin
			rvalid_next = 1'b0;
			arready_next = 1'b1;
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_reg <= 1'b1;
			wready_reg <= 1'b1;
			bvalid_reg <= 1'b0;
			bresp_reg <= `RESP_OKAY;
			have_aw_reg <= 1'b0;
			have_w_reg <= 1'b0;
			waddr_reg <= 8'h00;
			wdata_reg <= 32'h0000_0000;
			wstrb_reg <= 4'h0;
			arready_reg <= 1'b1;
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			rresp_reg <= `RESP_OKAY;
		end else begin
			awready_reg <= awready_next;
			wready_reg <= wready_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			have_aw_reg <= have_aw_next;
			have_w_reg <= have_w_next;
			waddr_reg <= waddr_next;
			wdata_reg <= wdata_next;
			wstrb_reg <= wstrb_next;
			arready_reg <= arready_next;
			rvalid_reg <= rvalid_next;
			rdata_reg <= rdata_next;
			rresp_reg <= rresp_next;
		end
	end
	always_comb begin
		state_next = state_reg;
		op_next = op_reg;
		accumulator_next = accumulator_reg;
		mem_next = mem_reg;
		{overflow_next, zero_next, aux_carry_next, carry_next} =
			{overflow_flag, zero_flag, aux_carry_flag, carry_flag};
		skip_nx = skip_reg;
		unique case (state_reg)
			st_idle: begin
				if (wr_commit && wstrb_reg[0]) begin
					unique case (waddr_reg)
						`OFF_CMD: begin
							// illegal codes are dropped rather than run
							if (wdata_reg[2:0] != 3'b000 && wdata_reg[2:0] <= 3'b101) begin
								op_next = op_t'(wdata_reg[2:0]);
								state_next = st_exec;
								skip_nx = 1'b0;
							end
						end
						`OFF_MEM: mem_next = wdata_reg[7:0];
						`OFF_ACC: accumulator_next = wdata_reg[7:0];
						// relies on the four flag bits sitting side by side in status
						`OFF_STATUS: {overflow_next, zero_next, aux_carry_next, carry_next} =
							wdata_reg[`BIT_OV:`BIT_C];
						default: ;
					endcase
				end
			end
			st_exec: begin
				state_next = st_idle;
				unique case (op_reg)
					op_sub_borrow_to_acc, op_sub_borrow_to_mem: begin
						if (op_reg == op_sub_borrow_to_acc)
							accumulator_next = sub_res.diff;
						else
							mem_next = sub_res.diff;
						{overflow_next, zero_next, aux_carry_next, carry_next} = {sub_res.ovf,
							sub_res.diff == 8'h00, ~sub_res.half_borrow, ~sub_res.borrow};
					end
					op_dec_skip_zero_mem, op_dec_skip_zero_acc: begin
						// flags are left alone on purpose
						if (op_reg == op_dec_skip_zero_mem)
							mem_next = dec_res;
						else
							accumulator_next = dec_res;
						skip_nx = (dec_res == 8'h00);
						state_next = st_dummy;
					end
					op_set_byte: mem_next = `SET_PATTERN;
					default: ;
				endcase
			end
			st_dummy: state_next = st_idle;
			default: state_next = st_idle;
		endcase
		busy_next = (state_next != st_idle);
		dummy_next = (state_next == st_dummy);
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= st_idle;
			op_reg <= op_none;
			accumulator_reg <= `ACC_RESET;
			mem_reg <= `MEM_RESET;
			{overflow_flag, zero_flag, aux_carry_flag, carry_flag} <= `FLAGS_RESET;
			skip_reg <= 1'b0;
			dummy_reg <= 1'b0;
			busy_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			op_reg <= op_next;
			accumulator_reg <= accumulator_next;
			mem_reg <= mem_next;
			{overflow_flag, zero_flag, aux_carry_flag, carry_flag} <=
				{overflow_next, zero_next, aux_carry_next, carry_next};
			skip_reg <= skip_nx;
			dummy_reg <= dummy_next;
			busy_reg <= busy_next;
		end
	end
	assign s_axi_awready = awready_reg;
	assign s_axi_wready = wready_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;
	assign skip_next = skip_reg;
	assign dummy_cycle = dummy_reg;
	assign busy = busy_reg;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic exec_sub, exec_dec;
	assign exec_sub = (state_reg == st_exec) &&
		(op_reg == op_sub_borrow_to_acc || op_reg == op_sub_borrow_to_mem);
	assign exec_dec = (state_reg == st_exec) &&
		(op_reg == op_dec_skip_zero_mem || op_reg == op_dec_skip_zero_acc);
	a_sub_acc_result: assert property (
		(state_reg == st_exec && op_reg == op_sub_borrow_to_acc) |=>
		accumulator_reg == 8'($past(accumulator_reg) - $past(mem_reg) - {7'h00, ~$past(carry_flag)})
		&& $stable(mem_reg))
		else $error("subtract to acc gave wrong accumulator");
	a_sub_carry_sign: assert property (
		exec_sub |=> carry_flag == ($past(accumulator_reg) >= 9'($past(mem_reg)) +
		9'({8'h00, ~$past(carry_flag)})))
		else $error("carry does not reflect sign of difference");
	a_sub_mem_result: assert property (
		(state_reg == st_exec && op_reg == op_sub_borrow_to_mem) |=>
		mem_reg == 8'($past(accumulator_reg) - $past(mem_reg) - {7'h00, ~$past(carry_flag)})
		&& $stable(accumulator_reg) && zero_flag == (mem_reg == 8'h00))
		else $error("subtract to memory gave wrong byte");
	a_dec_mem_skip: assert property (
		(state_reg == st_exec && op_reg == op_dec_skip_zero_mem) |=>
		mem_reg == 8'($past(mem_reg) - 8'h01) && skip_next == (mem_reg == 8'h00))
		else $error("decrement in memory or its skip is wrong");
	a_dec_acc_keep: assert property (
		(state_reg == st_exec && op_reg == op_dec_skip_zero_acc) |=>
		accumulator_reg == 8'($past(mem_reg) - 8'h01) && $stable(mem_reg)
		&& skip_next == (accumulator_reg == 8'h00))
		else $error("decrement to acc altered memory or skipped wrongly");
	a_dec_two_cycle: assert property (
		exec_dec |=> dummy_cycle && busy ##1 !busy && !dummy_cycle && state_reg == st_idle)
		else $error("decrement did not take exactly one dummy cycle");
	a_dec_no_skip: assert property (
		(exec_dec && dec_res != 8'h00) |=> !skip_next [*2])
		else $error("skip raised for a nonzero result");
	a_set_all_ones: assert property (
		(state_reg == st_exec && op_reg == op_set_byte) |=> mem_reg == 8'hFF
		&& $stable({overflow_flag, zero_flag, aux_carry_flag, carry_flag}) && !busy)
		else $error("set byte wrong or flags changed");
	a_dec_flags_kept: assert property (
		exec_dec |=> $stable({overflow_flag, zero_flag, aux_carry_flag, carry_flag}))
		else $error("decrement changed arithmetic flags");
endmodule

/* tb/axi_master_model.sv */
// Purpose: AXI4-Lite master standing in for the decoder side
// Assumes: one write and one read at a time
// Notes:   released address and data lines show inverted values
`timescale 1ns/1ps
module axi_master_model (
	input  wire logic        aclk,
	output logic [7:0]       s_axi_awaddr,
	output logic             s_axi_awvalid,
	input  wire logic        s_axi_awready,
	output logic [31:0]      s_axi_wdata,
	output logic [3:0]       s_axi_wstrb,
	output logic             s_axi_wvalid,
	input  wire logic        s_axi_wready,
	input  wire logic [1:0]  s_axi_bresp,
	input  wire logic        s_axi_bvalid,
	output logic             s_axi_bready,
	output logic [7:0]       s_axi_araddr,
	output logic             s_axi_arvalid,
	input  wire logic        s_axi_arready,
	input  wire logic [31:0] s_axi_rdata,
	input  wire logic [1:0]  s_axi_rresp,
	input  wire logic        s_axi_rvalid,
	output logic             s_axi_rready,
	output logic             timed_out
);
	initial begin
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
		{s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready, timed_out} = '0;
	end
	task automatic write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'h1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) begin
				s_axi_awvalid <= 1'b0;
				s_axi_awaddr <= ~a;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				s_axi_wvalid <= 1'b0;
				s_axi_wdata <= ~d;
			end
			if (s_axi_bvalid && s_axi_bready) break;
		end
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		// blocking so the caller sees it at once
		if (n == 50) timed_out = 1'b1;
	endtask
	task automatic read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arvalid <= 1'b0;
				s_axi_araddr <= ~a;
			end
			if (s_axi_rvalid && s_axi_rready) break;
		end
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		if (n == 50) timed_out = 1'b1;
	endtask
endmodule

/* tb/tb_subtract_skip_set_execution.sv */
// Purpose: self-checking bench of the execution block
// Assumes: one op at a time, busy polled before the next write
// Notes:   expected values come from the arithmetic in run_case
`timescale 1ns/1ps
`include "sub_skip_defs.svh"
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin failures++; \
	$display("MISMATCH %0t got %h exp %h", $time, a, e); end end
module tb_subtract_skip_set_execution;
	logic        aclk, aresetn, timed_out, skip_next, dummy_cycle, busy;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, q;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	int          failures, checks, dummies, busy_cycles;
	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		if (dummy_cycle === 1'b1) dummies++;
		if (busy === 1'b1) busy_cycles++;
	end
	subtract_skip_set_execution subtract_skip_set_execution_i (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .skip_next(skip_next),
		.dummy_cycle(dummy_cycle), .busy(busy));
	axi_master_model axi_master_model_i (.aclk(aclk), .timed_out(timed_out),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
	task automatic end_of_test();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic [1:0] r;
		axi_master_model_i.write(a, d, r);
		if (timed_out === 1'b1) begin
			failures++;
			end_of_test();
		end else
			`CHK(r, er)
	endtask
	task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
		logic [1:0] r;
		axi_master_model_i.read(a, d, r);
		if (timed_out === 1'b1) begin
			failures++;
			end_of_test();
		end else
			`CHK(r, er)
	endtask
	// loads acc, mem and flags, runs one opcode and checks every visible result
	task automatic run_case(input logic [2:0] op, input logic [7:0] a, input logic [7:0] m,
		input logic [3:0] f);
		logic [8:0] d9;
		logic [4:0] h5;
		logic [7:0] ea, em;
		logic [3:0] ef;
		logic       es, dec;
		int         n, d0, b0;
		dec = (op == 3'h3 || op == 3'h4);
		d9 = {1'b0, a} - {1'b0, m} - {8'h00, ~f[`BIT_C]};
		h5 = {1'b0, a[3:0]} - {1'b0, m[3:0]} - {4'h0, ~f[`BIT_C]};
		ea = (op == 3'h1) ? d9[7:0] : (op == 3'h4) ? m - `DEC_STEP : a;
		em = (op == 3'h2) ? d9[7:0] : (op == 3'h3) ? m - `DEC_STEP : (op == 3'h5) ? `SET_PATTERN : m;
		ef = f;
		if (op == 3'h1 || op == 3'h2)
			ef = {(a[7] ^ m[7]) & (d9[7] ^ a[7]), d9[7:0] == 8'h00, ~h5[4], ~d9[8]};
		es = dec && (m == `DEC_STEP);
		wr(`OFF_ACC, {24'h00_0000, a}, `RESP_OKAY);
		wr(`OFF_MEM, {24'h00_0000, m}, `RESP_OKAY);
		wr(`OFF_STATUS, {28'h000_0000, f}, `RESP_OKAY);
		d0 = dummies;
		b0 = busy_cycles;
		wr(`OFF_CMD, {29'h0000_0000, op}, `RESP_OKAY);
		for (n = 0; n < 20; n++) begin
			rd(`OFF_STATUS, `RESP_OKAY, q);
			if (q[`BIT_BUSY] === 1'b0) break;
		end
		// a block that never leaves busy is a hang: count it and stop here
		if (q[`BIT_BUSY] !== 1'b0) begin
			failures++;
			end_of_test();
		end
		`CHK(q[31:4], {26'h000_0000, 1'b0, es})
		`CHK(q[3:0], ef)
		`CHK(skip_next, es)
		rd(`OFF_ACC, `RESP_OKAY, q);
		`CHK(q, {24'h00_0000, ea})
		rd(`OFF_MEM, `RESP_OKAY, q);
		`CHK(q, {24'h00_0000, em})
		rd(`OFF_CMD, `RESP_OKAY, q);
		if (op >= 3'h1 && op <= 3'h5)
			`CHK(q, {29'h0000_0000, op})
		`CHK(dummies - d0, dec ? 1 : 0)
		`CHK(busy_cycles - b0, dec ? 2 : (op >= 3'h1 && op <= 3'h5) ? 1 : 0)
	endtask
	initial begin
		aresetn = 1'b0;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		rd(`OFF_ACC, `RESP_OKAY, q);
		`CHK(q[7:0], `ACC_RESET)
		rd(`OFF_MEM, `RESP_OKAY, q);
		`CHK(q[7:0], `MEM_RESET)
		rd(`OFF_STATUS, `RESP_OKAY, q);
		`CHK(q, 32'h0000_0000)
		rd(8'h10, `RESP_SLVERR, q);
		`CHK(q, 32'h0000_0000)
		wr(8'h10, 32'h0000_00FF, `RESP_SLVERR);
		run_case(3'h1, 8'h10, 8'h20, 4'h0);
		run_case(3'h1, 8'h50, 8'h30, 4'h1);
		run_case(3'h1, 8'h80, 8'h01, 4'h1);
		run_case(3'h2, 8'h05, 8'h04, 4'h0);
		run_case(3'h2, 8'h7F, 8'hFF, 4'h1);
		run_case(3'h3, 8'h33, 8'h01, 4'hF);
		run_case(3'h3, 8'h33, 8'h00, 4'h0);
		run_case(3'h4, 8'h55, 8'h01, 4'h5);
		run_case(3'h4, 8'h55, 8'h80, 4'hA);
		run_case(3'h0, 8'h12, 8'h34, 4'h3);
		run_case(3'h6, 8'h12, 8'h34, 4'h3);
		run_case(3'h5, 8'h12, 8'h34, 4'hA);
		end_of_test();
	end
endmodule
